/* File: arsc_consts.svh */
// Purpose: named offsets, field positions and reset values for the rx feature block
// Assumes: 3-bit cpu register address, 8-bit registers
// Notes: definitions only
`ifndef ARSC_CONSTS_SVH
`define ARSC_CONSTS_SVH

// ==========================================================
// register offsets
`define ARSC_OFF_MASK 3'h1
`define ARSC_OFF_IDENT 3'h2
`define ARSC_OFF_EFC 3'h2
`define ARSC_OFF_LCTL 3'h3
`define ARSC_OFF_MODEM 3'h4
`define ARSC_OFF_PAUSE2 3'h4
`define ARSC_OFF_FLAGS 3'h5

// ==========================================================
// access key and reset values
`define ARSC_LCTL_ENH_KEY 8'hbf
`define ARSC_RST_BYTE 8'h00

// ==========================================================
// field positions
`define ARSC_MASK_SPECIAL 5
`define ARSC_IDENT_NONE 0
`define ARSC_IDENT_SPECIAL 4
`define ARSC_EFC_AUTO_RTS 6
`define ARSC_EFC_SPECIAL 5
`define ARSC_MODEM_RTS 1
`define ARSC_FLAG_RTS 0
`define ARSC_FLAG_PAUSE 1
`define ARSC_FLAG_SPECIAL 2

// ==========================================================
// comparison select codes (enhanced_feature_ctrl bits 1:0)
`define ARSC_EFC_SEL_HI 1
`define ARSC_EFC_SEL_LO 0
`define ARSC_SEL_FIRST 2'h2
`define ARSC_SEL_SECOND 2'h1

`endif

/* File: arsc_pkg.sv */
// Purpose: shared types of the rx feature block
// Assumes: nothing
// Notes: carriers only, constants live in arsc_consts.svh
package arsc_pkg;

    // one received character handed over by the receiver
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } arsc_rx_t;

    // cpu register write/read request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } arsc_cpu_t;

    // character pushed into the receive fifo
    typedef struct packed {
        logic push;
        logic [7:0] data;
    } arsc_push_t;

endpackage

/* File: arsc_rx_feature.sv */
// Purpose: auto rts flow control and special character detection of one uart channel
// Assumes: receiver, fifo and cpu strobes all run on clock
// Notes: register reads answer one cycle after the read strobe
//
// Functional notes
// R1 - auto rts on: at fifo trigger level, rts goes high and interrupt raised
// R2 - host must first assert rts low through modem control before auto rts acts
// R3 - special detect compares each received char with second pause code register
// R4 - on match char goes to fifo; ident bit 4 set if mask bit 5 set
// R5 - pattern bit 0 lines up with received character lsb
// R6 - select 10: flow control and special detect work independently
// R7 - select 01: second pause code not stored, raises pause and special interrupt
// R8 - pending special interrupt clears itself on next received character
// R9 - auto rts: rts asserted again once fifo level falls below trigger
// R10 - after reset auto rts and special detect off, rts host controlled
`timescale 1ns/1ns
`include "arsc_consts.svh"

module arsc_rx_feature #(
    parameter int LEVEL_W = 7
) (
    input wire logic clock,
    input wire logic rstn,
    input wire arsc_pkg::arsc_cpu_t cpuReq,
    input wire arsc_pkg::arsc_rx_t rxChar,
    input wire logic [LEVEL_W-1:0] fifoLevel,
    input wire logic [LEVEL_W-1:0] fifoTrigger,
    output logic [7:0] cpuRdata_r,
    output arsc_pkg::arsc_push_t fifoPush_r,
    output logic rtsPinN_r,
    output logic irq_r
);

    // ==========================================================
    // register hit decode
    function automatic logic regHit(input logic [2:0] addr, input logic [2:0] off,
                                    input logic enh, input logic wantEnh);
        regHit = (addr == off) && (enh == wantEnh);
    endfunction

    // ==========================================================
    // state
    logic [7:0] mask_r, mask_nxt;
    logic [7:0] lctl_r, lctl_nxt;
    logic [7:0] modem_r, modem_nxt;
    logic [7:0] efc_r, efc_nxt;
    logic [7:0] pause2_r, pause2_nxt;
    logic [7:0] cpuRdata_nxt;
    arsc_pkg::arsc_push_t fifoPush_nxt;
    logic rtsPinN_nxt;
    logic irq_nxt;
    logic rtsFlag_r, rtsFlag_nxt;
    logic pauseFlag_r, pauseFlag_nxt;
    logic specialFlag_r, specialFlag_nxt;

    logic enh;
    logic match;
    logic swallow;
    logic atTrigger;
    logic flagsRead;

    // decode helpers
    assign enh = (lctl_r == `ARSC_LCTL_ENH_KEY);
    assign match = efc_r[`ARSC_EFC_SPECIAL] && rxChar.valid
                   && (rxChar.data == pause2_r); // R3 R5
    // second pause code under select 01 is swallowed instead of stored
    assign swallow = match
                     && (efc_r[`ARSC_EFC_SEL_HI:`ARSC_EFC_SEL_LO] == `ARSC_SEL_SECOND); // R7
    assign atTrigger = (fifoLevel >= fifoTrigger);
    assign flagsRead = cpuReq.rd && regHit(cpuReq.addr, `ARSC_OFF_FLAGS, enh, 1'b0);

    // ==========================================================
    // next values of the cpu written registers
    always_comb begin
        mask_nxt = mask_r;
        lctl_nxt = lctl_r;
        modem_nxt = modem_r;
        efc_nxt = efc_r;
        pause2_nxt = pause2_r;

        // cpu writes
        if (cpuReq.wr) begin
            if (regHit(cpuReq.addr, `ARSC_OFF_MASK, enh, 1'b0)) begin
                mask_nxt = cpuReq.wdata;
            end
            if (cpuReq.addr == `ARSC_OFF_LCTL) begin
                lctl_nxt = cpuReq.wdata;
            end
            if (regHit(cpuReq.addr, `ARSC_OFF_MODEM, enh, 1'b0)) begin
                modem_nxt = cpuReq.wdata;
            end
            if (regHit(cpuReq.addr, `ARSC_OFF_EFC, enh, 1'b1)) begin
                efc_nxt = cpuReq.wdata;
            end
            if (regHit(cpuReq.addr, `ARSC_OFF_PAUSE2, enh, 1'b1)) begin
                pause2_nxt = cpuReq.wdata; // R3
            end
        end
    end

    // cpu written registers; reset turns auto rts and special detect off
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mask_r <= `ARSC_RST_BYTE;
            lctl_r <= `ARSC_RST_BYTE;
            modem_r <= `ARSC_RST_BYTE;
            efc_r <= `ARSC_RST_BYTE; // R10
            pause2_r <= `ARSC_RST_BYTE;
        end else begin
            mask_r <= mask_nxt;
            lctl_r <= lctl_nxt;
            modem_r <= modem_nxt;
            efc_r <= efc_nxt;
            pause2_r <= pause2_nxt;
        end
    end

    // ==========================================================
    // next values of the sticky interrupt flags
    always_comb begin
        rtsFlag_nxt = rtsFlag_r;
        pauseFlag_nxt = pauseFlag_r;
        specialFlag_nxt = specialFlag_r;

        // reading the flag register clears the sticky rts and pause flags
        if (flagsRead) begin
            rtsFlag_nxt = 1'b0;
            pauseFlag_nxt = 1'b0;
        end

        // special flag: any received char clears it, a match with mask bit 5 set sets it again
        if (rxChar.valid) begin
            specialFlag_nxt = 1'b0; // R8
        end
        if (match && mask_r[`ARSC_MASK_SPECIAL]) begin
            specialFlag_nxt = 1'b1; // R4 R7
        end

        // second pause code under select 01 raises the pause interrupt
        if (swallow) begin
            pauseFlag_nxt = 1'b1; // R7
        end

        // auto rts trips at trigger level; set wins over read clear
        if (efc_r[`ARSC_EFC_AUTO_RTS] && modem_r[`ARSC_MODEM_RTS] && atTrigger
            && !rtsPinN_r) begin
            rtsFlag_nxt = 1'b1; // R1
        end
    end

    // sticky interrupt flags
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rtsFlag_r <= 1'b0;
            pauseFlag_r <= 1'b0;
            specialFlag_r <= 1'b0;
        end else begin
            rtsFlag_r <= rtsFlag_nxt;
            pauseFlag_r <= pauseFlag_nxt;
            specialFlag_r <= specialFlag_nxt;
        end
    end

    // ==========================================================
    // next values of the pin, push, interrupt and read data outputs
    always_comb begin
        cpuRdata_nxt = cpuRdata_r;

        // rts pin: low only when host asserts it and auto rts does not hold it off
        rtsPinN_nxt = !(modem_r[`ARSC_MODEM_RTS]
                        && !(efc_r[`ARSC_EFC_AUTO_RTS] && atTrigger)); // R1 R2 R9 R10

        // receive fifo push, suppressed for second pause code under select 01
        fifoPush_nxt.push = rxChar.valid && !swallow; // R4 R6 R7
        fifoPush_nxt.data = rxChar.data;

        // single interrupt line
        irq_nxt = rtsFlag_nxt || pauseFlag_nxt || specialFlag_nxt;

        // cpu reads
        if (cpuReq.rd) begin
            cpuRdata_nxt = `ARSC_RST_BYTE;
            case (cpuReq.addr)
                `ARSC_OFF_MASK: begin
                    cpuRdata_nxt = enh ? `ARSC_RST_BYTE : mask_r;
                end
                `ARSC_OFF_IDENT: begin
                    if (enh) begin
                        cpuRdata_nxt = efc_r;
                    end else begin
                        cpuRdata_nxt[`ARSC_IDENT_SPECIAL] = specialFlag_r; // R4
                        cpuRdata_nxt[`ARSC_IDENT_NONE] = !irq_r;
                    end
                end
                `ARSC_OFF_LCTL: begin
                    cpuRdata_nxt = lctl_r;
                end
                `ARSC_OFF_MODEM: begin
                    cpuRdata_nxt = enh ? pause2_r : modem_r;
                end
                `ARSC_OFF_FLAGS: begin
                    if (!enh) begin
                        cpuRdata_nxt[`ARSC_FLAG_RTS] = rtsFlag_r;
                        cpuRdata_nxt[`ARSC_FLAG_PAUSE] = pauseFlag_r;
                        cpuRdata_nxt[`ARSC_FLAG_SPECIAL] = specialFlag_r;
                    end
                end
                default: begin
                    cpuRdata_nxt = `ARSC_RST_BYTE;
                end
            endcase
        end
    end

    // ==========================================================
    // output registers; rts pin starts high, host controlled
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cpuRdata_r <= `ARSC_RST_BYTE;
            fifoPush_r <= '0;
            rtsPinN_r <= 1'b1; // R10
            irq_r <= 1'b0;
        end else begin
            cpuRdata_r <= cpuRdata_nxt;
            fifoPush_r <= fifoPush_nxt;
            rtsPinN_r <= rtsPinN_nxt;
            irq_r <= irq_nxt;
        end
    end

endmodule

/* File: arsc_rx_feature_asserts.sv */
// Purpose: port checks of the rx feature block
// Assumes: one clock domain
// Notes: bound onto arsc_rx_feature
`timescale 1ns/1ns
module arsc_rx_feature_asserts #(
    parameter int LEVEL_W = 7
) (
    input wire logic clock,
    input wire logic rstn,
    input wire arsc_pkg::arsc_cpu_t cpuReq,
    input wire arsc_pkg::arsc_rx_t rxChar,
    input wire logic [LEVEL_W-1:0] fifoLevel,
    input wire logic [LEVEL_W-1:0] fifoTrigger,
    input wire logic [7:0] cpuRdata_r,
    input wire arsc_pkg::arsc_push_t fifoPush_r,
    input wire logic rtsPinN_r,
    input wire logic irq_r
);
    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    sequence s_drop; rxChar.valid ##1 !fifoPush_r.push; endsequence
    sequence s_trip; $rose(rtsPinN_r) && !$past(cpuReq.wr, 2); endsequence
    property p_push; fifoPush_r.push |-> $past(rxChar.valid); endproperty
    a_push: assert property (p_push) else $error("push without character");
    property p_data; fifoPush_r.push |-> fifoPush_r.data == $past(rxChar.data); endproperty
    a_data: assert property (p_data) else $error("pushed data differs");
    property p_drop; s_drop |-> irq_r; endproperty
    a_drop: assert property (p_drop) else $error("dropped char, no irq");
    property p_fall; $fell(irq_r) |-> $past(rxChar.valid) || $past(cpuReq.rd, 2)
        || $past(cpuReq.rd); endproperty
    a_fall: assert property (p_fall) else $error("irq dropped with no cause");
    property p_trip; s_trip |-> ##[0:1] irq_r; endproperty
    a_trip: assert property (p_trip) else $error("rts trip without irq");
    property p_rise; $rose(rtsPinN_r) |-> $past(cpuReq.wr, 2)
        || ($past(fifoLevel) >= $past(fifoTrigger)); endproperty
    a_rise: assert property (p_rise) else $error("rts rose with no cause");
    property p_res; $fell(rtsPinN_r) |-> $past(cpuReq.wr, 2)
        || ($past(fifoLevel) < $past(fifoTrigger)); endproperty
    a_res: assert property (p_res) else $error("rts fell while full");
    property p_hold; !$past(cpuReq.rd) |-> $stable(cpuRdata_r); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind arsc_rx_feature arsc_rx_feature_asserts #(.LEVEL_W(LEVEL_W)) chk (.clock(clock),
    .rstn(rstn), .cpuReq(cpuReq), .rxChar(rxChar), .fifoLevel(fifoLevel),
    .fifoTrigger(fifoTrigger), .cpuRdata_r(cpuRdata_r), .fifoPush_r(fifoPush_r),
    .rtsPinN_r(rtsPinN_r), .irq_r(irq_r));

/* File: arsc_remote_tx.sv */
// Purpose: remote transmitter feeding the receive side
// Assumes: characters arrive already deframed
// Notes: sends only while rts is low
`timescale 1ns/1ns
module arsc_remote_tx (
    input wire logic clock,
    input wire logic rstn,
    input wire logic go,
    input wire logic [7:0] goData,
    input wire logic rtsPinN,
    output arsc_pkg::arsc_rx_t rxChar
);
    // ==========================================================
    // one strobe per request, idle data toggles
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rxChar <= '0;
        end else if (go && !rtsPinN) begin
            rxChar <= {1'b1, goData};
        end else begin
            rxChar <= {1'b0, ~rxChar.data};
        end
    end
endmodule

/* File: uart_auto_rts_special_char_bench.sv */
// Purpose: self-checking bench of the rx feature block
// Assumes: 100 MHz clock
// Notes: remote model feeds characters
`timescale 1ns/1ns
`include "arsc_consts.svh"
module uart_auto_rts_special_char_bench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic go = 1'b0;
    logic [7:0] goData = 8'h00;
    logic [6:0] lvl = 7'h00;
    logic [6:0] trig = 7'h08;
    arsc_pkg::arsc_cpu_t cpuReq = '0;
    arsc_pkg::arsc_rx_t rxChar;
    arsc_pkg::arsc_push_t push;
    logic [7:0] rdata;
    logic rtsN;
    logic irq;
    int err_total = 0;
    int num_checks = 0;
    // ==========================================================
    // design and far side
    arsc_rx_feature DUT (.clock(clock), .rstn(rstn), .cpuReq(cpuReq), .rxChar(rxChar),
        .fifoLevel(lvl), .fifoTrigger(trig), .cpuRdata_r(rdata), .fifoPush_r(push),
        .rtsPinN_r(rtsN), .irq_r(irq));
    arsc_remote_tx tx (.clock(clock), .rstn(rstn), .go(go), .goData(goData),
        .rtsPinN(rtsN), .rxChar(rxChar));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic r, input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        cpuReq <= {~r, r, a, d};
        @(posedge clock);
        cpuReq <= '0;
        #1;
    endtask
    task automatic cfg(input logic [7:0] efc);
        bus(1'b0, `ARSC_OFF_LCTL, `ARSC_LCTL_ENH_KEY);
        bus(1'b0, `ARSC_OFF_EFC, efc);
        bus(1'b0, `ARSC_OFF_PAUSE2, 8'h13);
        bus(1'b1, `ARSC_OFF_PAUSE2, 8'h00);
        chk(rdata, 8'h13);
        bus(1'b0, `ARSC_OFF_LCTL, 8'h03);
    endtask
    // level change, then irq and rts pin seen together
    task automatic lv(input logic [6:0] v, input logic [7:0] exp);
        @(posedge clock);
        lvl <= v;
        repeat (2) @(posedge clock);
        #1;
        chk({irq, 6'h00, rtsN}, exp);
    endtask
    // one character from the far side, pushed byte or 00 expected
    task automatic snd(input logic [7:0] d, input logic [7:0] exp);
        @(posedge clock);
        go <= 1'b1;
        goData <= d;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        #1;
        chk(push.push ? push.data : 8'h00, exp);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        bus(1'b1, a, 8'h00);
        chk(rdata, exp);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // tests
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        lv(7'h08, 8'h01);
        rdc(`ARSC_OFF_IDENT, 8'h01);
        $display("test reset done");
        cfg(8'h40);
        lv(7'h08, 8'h01);
        lv(7'h07, 8'h01);
        bus(1'b0, `ARSC_OFF_MODEM, 8'h02);
        cfg(8'h40);
        lv(7'h08, 8'h81);
        rdc(`ARSC_OFF_FLAGS, 8'h01);
        lv(7'h07, 8'h00);
        $display("test rts done");
        cfg(8'h21);
        bus(1'b0, `ARSC_OFF_MASK, 8'h20);
        snd(8'hc8, 8'hc8);
        snd(8'h13, 8'h00);
        rdc(`ARSC_OFF_IDENT, 8'h10);
        snd(8'h41, 8'h41);
        rdc(`ARSC_OFF_FLAGS, 8'h02);
        rdc(`ARSC_OFF_IDENT, 8'h01);
        cfg(8'h22);
        snd(8'h13, 8'h13);
        rdc(`ARSC_OFF_IDENT, 8'h10);
        bus(1'b0, `ARSC_OFF_MASK, 8'h00);
        snd(8'h13, 8'h13);
        rdc(`ARSC_OFF_IDENT, 8'h01);
        $display("test special done");
        summarize();
    end
endmodule
